/* File: inc/usr_pkg.sv */
// Constants, types and function list for the async serial receive path
// Function
// - Recover data with sixteen-times oversampling clock
// - Receive only after continuous enable is set
// - Stop bit moves word to buffer, flag
// - Flag read-only, clears when buffer empty
// - Interrupt gated by receive interrupt enable bit
// - Two-entry buffer plus word in shifter
// - Two reads return words in arrival order
// - Third word with full buffer sets overrun
// - Overrun blocks all transfers into buffer
// - Overrun clears only by toggling continuous enable
// - Stop bit zero sets framing error
// - Framing and ninth bit queued per word
// - Ninth bit enable selects nine data bits
// - Address detect bit enables address detection in nine-bit mode only
// - Address detect drops data words, no interrupt
// - Sync master mode is half duplex
// - Sync bit selects sync, pins reassigned
// - Clock source bit drives clock line in sync mode only
// - Baud base tick is x16 or x64 bit rate
// - NRZ, start, LSB first data, stop
package usr_pkg;

  localparam logic [7:0] USR_PERIPHERAL_FLAGS_OFS       = 8'h0C;
  localparam logic [7:0] USR_RECEIVE_CONTROL_STATUS_OFS = 8'h18;
  localparam logic [7:0] USR_TRANSMIT_BUFFER_OFS        = 8'h19;
  localparam logic [7:0] USR_RECEIVE_BUFFER_OFS         = 8'h1A;
  localparam logic [7:0] USR_PERIPHERAL_IRQ_ENABLE_OFS  = 8'h8C;
  localparam logic [7:0] USR_TRANSMIT_CONTROL_STATUS_OFS = 8'h98;
  localparam logic [7:0] USR_BAUD_DIVISOR_OFS           = 8'h99;

  // Field positions
  localparam int USR_RECEIVE_FLAG_BIT        = 5;
  localparam int USR_TRANSMIT_FLAG_BIT       = 4;
  localparam int USR_RECEIVE_IRQ_ENABLE_BIT  = 5;
  localparam int USR_TRANSMIT_IRQ_ENABLE_BIT = 4;
  localparam int USR_SERIAL_PORT_ENABLE_BIT  = 7;
  localparam int USR_NINE_BIT_RECEIVE_BIT    = 6;
  localparam int USR_SINGLE_RECEIVE_BIT      = 5;
  localparam int USR_CONTINUOUS_RECEIVE_BIT  = 4;
  localparam int USR_ADDRESS_DETECT_BIT      = 3;
  localparam int USR_FRAMING_ERROR_BIT       = 2;
  localparam int USR_OVERRUN_ERROR_BIT       = 1;
  localparam int USR_RECEIVED_NINTH_BIT      = 0;
  localparam int USR_CLOCK_SOURCE_MASTER_BIT = 7;
  localparam int USR_SYNC_MODE_BIT           = 4;
  localparam int USR_TRANSMIT_ENABLE_BIT     = 5;
  localparam int USR_HIGH_SPEED_BAUD_BIT     = 2;
  localparam int USR_SHIFT_REG_EMPTY_BIT     = 1;

  // Writable bit masks
  localparam logic [7:0] USR_RCS_WRITE_MASK = 8'hF8;
  localparam logic [7:0] USR_TCS_WRITE_MASK = 8'hF5;
  localparam logic [7:0] USR_PIE_WRITE_MASK = 8'h30;

  // Values after reset
  localparam logic [7:0] USR_RCS_RESET  = 8'h00;
  localparam logic [7:0] USR_TCS_RESET  = 8'h02;
  localparam logic [7:0] USR_PIE_RESET  = 8'h00;
  localparam logic [7:0] USR_TXB_RESET  = 8'h00;
  localparam logic [7:0] USR_BAUD_RESET = 8'h00;

  // Cycle counts
  localparam logic [3:0] USR_MID_SAMPLE  = 4'h7;
  localparam logic [3:0] USR_LAST_SAMPLE = 4'hF;
  localparam logic [1:0] USR_SLOW_PRE_LAST = 2'h3;
  localparam logic [3:0] USR_LAST_BIT_8  = 4'h7;
  localparam logic [3:0] USR_LAST_BIT_9  = 4'h8;

  typedef struct packed {
    logic       framing_error_flag;
    logic       ninth;
    logic [7:0] data;
  } usr_word_type;

  typedef enum logic [3:0] {
    USR_IDLE  = 4'b0001,
    USR_START = 4'b0010,
    USR_DATA  = 4'b0100,
    USR_STOP  = 4'b1000
  } usr_state_type;

endpackage

/* File: src/usr_receiver.sv */
// Async receive path: baud sampler, shifter, two-word buffer, registers
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module usr_receiver
  import usr_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       rx_pin_in,
  input  wire logic       tx_active_in,
  output logic      [7:0] rdata_out,
  output logic            rx_irq_out,
  output logic            tx_inhibit_out,
  output logic            sync_clock_out,
  output logic            sync_clock_oe_n_out,
  output logic            sync_data_oe_n_out
);

  // Register state
  logic [7:0]   rcs_ctl;
  logic [7:0]   tcs_ctl;
  logic [7:0]   pie;
  logic [7:0]   txb;
  logic [7:0]   baud_div;
  logic         overrun_error_flag;
  usr_word_type fifo [2];
  logic [1:0]   count;
  logic [7:0]   next_rcs_ctl;
  logic [7:0]   next_tcs_ctl;
  logic [7:0]   next_pie;
  logic [7:0]   next_txb;
  logic [7:0]   next_baud_div;
  logic         next_overrun_error_flag;
  usr_word_type next_fifo [2];
  logic [1:0]   count_less;
  logic [1:0]   next_count;
  logic [7:0]   next_rdata;
  logic         next_irq;
  logic         next_tx_inhibit;
  logic         pop;
  logic         push;
  logic         receive_flag;

  // Baud state
  logic [7:0]   brg_cnt;
  logic [1:0]   pre;
  logic         sample_en;
  logic [7:0]   next_brg_cnt;
  logic [1:0]   next_pre;
  logic         next_sample_en;

  // Receive state
  usr_state_type state;
  usr_state_type next_state;
  logic [3:0]   scnt;
  logic [3:0]   next_scnt;
  logic [3:0]   bitcnt;
  logic [3:0]   next_bitcnt;
  logic [8:0]   shreg;
  logic [8:0]   next_shreg;
  logic         done;
  logic         next_done;
  usr_word_type done_word;
  usr_word_type next_done_word;
  logic         rx_meta;
  logic         rx_sync;
  logic         sclk;
  logic         next_sclk;
  logic         sclk_oe_n;
  logic         next_sclk_oe_n;

  // Control decode
  logic serial_port_enable;
  logic rx9;
  logic single_receive_enable;
  logic continuous_receive_enable;
  logic address_detect_enable;
  logic clock_source_master;
  logic sync_mode;
  logic transmit_enable_bit;
  logic high_speed_baud_select;
  logic receive_irq_enable;
  logic rx_en;
  logic brg_run;
  logic master_clk;

  assign serial_port_enable       = rcs_ctl[USR_SERIAL_PORT_ENABLE_BIT];
  assign rx9        = rcs_ctl[USR_NINE_BIT_RECEIVE_BIT];
  assign single_receive_enable       = rcs_ctl[USR_SINGLE_RECEIVE_BIT];
  assign continuous_receive_enable       = rcs_ctl[USR_CONTINUOUS_RECEIVE_BIT];
  assign address_detect_enable      = rcs_ctl[USR_ADDRESS_DETECT_BIT];
  assign clock_source_master       = tcs_ctl[USR_CLOCK_SOURCE_MASTER_BIT];
  assign sync_mode  = tcs_ctl[USR_SYNC_MODE_BIT];
  assign transmit_enable_bit       = tcs_ctl[USR_TRANSMIT_ENABLE_BIT];
  assign high_speed_baud_select       = tcs_ctl[USR_HIGH_SPEED_BAUD_BIT];
  assign receive_irq_enable       = pie[USR_RECEIVE_IRQ_ENABLE_BIT];
  assign receive_flag       = (count != 2'h0);
  // Async receiver runs only in async mode with continuous enable set
  assign rx_en      = serial_port_enable & ~sync_mode & continuous_receive_enable;
  // Generator held in reset while all enables are clear
  assign brg_run    = continuous_receive_enable | single_receive_enable | transmit_enable_bit;
  assign master_clk = serial_port_enable & sync_mode & clock_source_master;

  // ---------------------------------------------------------------
  // Baud generator: base tick every divisor+1 cycles; in low speed
  // mode the base is x64, so only every fourth tick samples.
  always_comb begin
    next_brg_cnt   = brg_cnt;
    next_pre       = pre;
    next_sample_en = 1'b0;
    if (!brg_run) begin
      next_brg_cnt = 8'h00;
      next_pre     = 2'h0;
    end else if (brg_cnt == 8'h00) begin
      next_brg_cnt   = baud_div;
      next_pre       = pre + 2'h1;
      next_sample_en = high_speed_baud_select | (pre == USR_SLOW_PRE_LAST);
    end else begin
      next_brg_cnt = brg_cnt - 8'h01;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      brg_cnt   <= 8'h00;
      pre       <= 2'h0;
      sample_en <= 1'b0;
    end else begin
      brg_cnt   <= next_brg_cnt;
      pre       <= next_pre;
      sample_en <= next_sample_en;
    end
  end

  // ---------------------------------------------------------------
  // Receive shifter, sixteen samples per bit, decision at mid bit.
  // Single mid sample: no noise vote, cheaper, fine for clean lines.
  always_comb begin
    next_state     = state;
    next_scnt      = scnt;
    next_bitcnt    = bitcnt;
    next_shreg     = shreg;
    next_done      = 1'b0;
    next_done_word = done_word;
    next_sclk      = sclk;
    next_sclk_oe_n = ~master_clk;
    // Clock line steps on sample ticks, so it stands still until
    // a transmit or receive enable starts the generator
    if (master_clk && sample_en && scnt == USR_MID_SAMPLE) begin
      next_sclk = ~sclk;
    end
    if (!master_clk) begin
      next_sclk = 1'b0;
    end
    if (sample_en) begin
      next_scnt = scnt + 4'h1;
    end
    // Half duplex: transmitter busy in sync mode blocks reception
    if (!rx_en || (sync_mode && tx_active_in)) begin
      next_state  = USR_IDLE;
      next_bitcnt = 4'h0;
    end else if (sample_en) begin
      unique case (state)
        USR_IDLE: begin
          next_scnt = 4'h0;
          if (!rx_sync) begin
            next_state = USR_START;
          end
        end
        USR_START: begin
          if (scnt == USR_MID_SAMPLE && rx_sync) begin
            next_state = USR_IDLE;
          end else if (scnt == USR_LAST_SAMPLE) begin
            next_state  = USR_DATA;
            next_bitcnt = 4'h0;
          end
        end
        USR_DATA: begin
          if (scnt == USR_MID_SAMPLE) begin
            next_shreg = {rx_sync, shreg[8:1]};
          end else if (scnt == USR_LAST_SAMPLE) begin
            if (bitcnt == (rx9 ? USR_LAST_BIT_9 : USR_LAST_BIT_8)) begin
              next_state = USR_STOP;
            end else begin
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        USR_STOP: begin
          if (scnt == USR_MID_SAMPLE) begin
            next_state          = USR_IDLE;
            next_done           = 1'b1;
            next_done_word.framing_error_flag = ~rx_sync;
            next_done_word.ninth = rx9 & shreg[8];
            next_done_word.data = rx9 ? shreg[7:0] : shreg[8:1];
          end
        end
        default: begin
          next_state = USR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state     <= USR_IDLE;
      scnt      <= 4'h0;
      bitcnt    <= 4'h0;
      shreg     <= 9'h000;
      done      <= 1'b0;
      done_word <= '0;
      rx_meta   <= 1'b1;
      rx_sync   <= 1'b1;
      sclk      <= 1'b0;
      sclk_oe_n <= 1'b1;
    end else begin
      state     <= next_state;
      scnt      <= next_scnt;
      bitcnt    <= next_bitcnt;
      shreg     <= next_shreg;
      done      <= next_done;
      done_word <= next_done_word;
      rx_meta   <= rx_pin_in;
      rx_sync   <= rx_meta;
      sclk      <= next_sclk;
      sclk_oe_n <= next_sclk_oe_n;
    end
  end

  // ---------------------------------------------------------------
  // Registers and the two-word buffer; head always sits in entry 0.
  always_comb begin
    next_rcs_ctl  = rcs_ctl;
    next_tcs_ctl  = tcs_ctl;
    next_pie      = pie;
    next_txb      = txb;
    next_baud_div = baud_div;
    next_fifo     = fifo;
    next_overrun_error_flag     = overrun_error_flag;
    push          = 1'b0;
    pop = rd_in && addr_in == USR_RECEIVE_BUFFER_OFS && receive_flag;
    // Receive reset wins over a same-cycle overrun; queued words stay
    if (!continuous_receive_enable) begin
      next_overrun_error_flag = 1'b0;
    end else if (done && !overrun_error_flag) begin
      if (count == 2'h2 && !pop) begin
        next_overrun_error_flag = 1'b1;
      end else if (!(address_detect_enable && rx9 && !done_word.ninth)) begin
        push = 1'b1;
      end
    end
    count_less = count - {1'b0, pop};
    if (pop) begin
      next_fifo[0] = fifo[1];
    end
    if (push) begin
      next_fifo[count_less[0]] = done_word;
    end
    next_count = count_less + {1'b0, push};
    if (wr_in) begin
      unique case (addr_in)
        USR_RECEIVE_CONTROL_STATUS_OFS:
          next_rcs_ctl = wdata_in & USR_RCS_WRITE_MASK;
        USR_TRANSMIT_CONTROL_STATUS_OFS:
          next_tcs_ctl = (wdata_in & USR_TCS_WRITE_MASK) |
                         (tcs_ctl & ~USR_TCS_WRITE_MASK);
        USR_PERIPHERAL_IRQ_ENABLE_OFS:
          next_pie = wdata_in & USR_PIE_WRITE_MASK;
        USR_TRANSMIT_BUFFER_OFS:
          next_txb = wdata_in;
        USR_BAUD_DIVISOR_OFS:
          next_baud_div = wdata_in;
        default: begin
        end
      endcase
    end
    next_rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        USR_PERIPHERAL_FLAGS_OFS:
          next_rdata = {2'b00, receive_flag, 5'b00000};
        USR_RECEIVE_CONTROL_STATUS_OFS:
          next_rdata = {rcs_ctl[7:3], fifo[0].framing_error_flag & receive_flag, overrun_error_flag,
                        fifo[0].ninth & receive_flag};
        USR_RECEIVE_BUFFER_OFS:
          next_rdata = fifo[0].data;
        USR_PERIPHERAL_IRQ_ENABLE_OFS:
          next_rdata = pie;
        USR_TRANSMIT_CONTROL_STATUS_OFS:
          next_rdata = tcs_ctl;
        USR_TRANSMIT_BUFFER_OFS:
          next_rdata = txb;
        USR_BAUD_DIVISOR_OFS:
          next_rdata = baud_div;
        default:
          next_rdata = 8'h00;
      endcase
    end
    next_irq        = receive_flag & receive_irq_enable;
    next_tx_inhibit = serial_port_enable & sync_mode & (continuous_receive_enable | single_receive_enable);
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rcs_ctl        <= USR_RCS_RESET;
      tcs_ctl        <= USR_TCS_RESET;
      pie            <= USR_PIE_RESET;
      txb            <= USR_TXB_RESET;
      baud_div       <= USR_BAUD_RESET;
      overrun_error_flag           <= 1'b0;
      fifo[0]        <= '0;
      fifo[1]        <= '0;
      count          <= 2'h0;
      rdata_out      <= 8'h00;
      rx_irq_out     <= 1'b0;
      tx_inhibit_out <= 1'b0;
    end else begin
      rcs_ctl        <= next_rcs_ctl;
      tcs_ctl        <= next_tcs_ctl;
      pie            <= next_pie;
      txb            <= next_txb;
      baud_div       <= next_baud_div;
      overrun_error_flag           <= next_overrun_error_flag;
      fifo           <= next_fifo;
      count          <= next_count;
      rdata_out      <= next_rdata;
      rx_irq_out     <= next_irq;
      tx_inhibit_out <= next_tx_inhibit;
    end
  end

  assign sync_clock_out      = sclk;
  assign sync_clock_oe_n_out = sclk_oe_n;
  // Receiver never drives the data line
  assign sync_data_oe_n_out  = 1'b1;

  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_shift_mid_sample: assert property (
    (state == USR_DATA && !sample_en) |=> $stable(shreg))
    else $error("shifter moved without a sample tick");
  a_idle_when_off: assert property (
    !rx_en |=> state == USR_IDLE)
    else $error("receiver active while disabled");
  a_flag_clears_empty: assert property (
    (count == 2'h1 && pop && !push) |=> !receive_flag)
    else $error("flag not cleared on empty");
  a_irq_gated: assert property (
    rx_irq_out |-> $past(receive_irq_enable) && $past(receive_flag))
    else $error("interrupt without enable and flag");
  a_fifo_order: assert property (
    (pop && count == 2'h2 && !push) |=> fifo[0] == $past(fifo[1]))
    else $error("buffer order broken");
  a_overrun_set: assert property (
    (done && continuous_receive_enable && !overrun_error_flag && count == 2'h2 && !pop) |=> overrun_error_flag)
    else $error("overrun not flagged");
  a_overrun_block: assert property (
    overrun_error_flag |=> count <= $past(count))
    else $error("buffer filled during overrun");
  a_overrun_clear: assert property (
    (overrun_error_flag && continuous_receive_enable) |=> overrun_error_flag)
    else $error("overrun cleared without receive reset");
  a_framing_error_flag_queued: assert property (
    (done && continuous_receive_enable && !overrun_error_flag && count == 2'h0 &&
     !(address_detect_enable && rx9 && !done_word.ninth))
    |=> fifo[0].framing_error_flag == $past(done_word.framing_error_flag) && count == 2'h1)
    else $error("framing flag not queued with word");
  a_addr_filter: assert property (
    (done && address_detect_enable && rx9 && !done_word.ninth) |=> count <= $past(count))
    else $error("data word passed address filter");

endmodule

/* File: sim/usr_far_tx.sv */
// Remote async transmitter that drives the receive line
`timescale 1ns/1ps
module usr_far_tx (
  input  wire logic clk_in,
  output logic      line_out
);
  initial line_out = 1'b1;

  // Bit time is 16 clocks: divisor 0 with high-speed sampling
  task automatic send(input logic [8:0] word,
                      input int         bits,
                      input logic       stop_level);
    line_out <= 1'b0;
    repeat (16) @(posedge clk_in);
    for (int i = 0; i < bits; i++) begin
      line_out <= word[i];
      repeat (16) @(posedge clk_in);
    end
    line_out <= stop_level;
    // A bad stop is cut short, else idle looks like a new start
    repeat (stop_level ? 16 : 12) @(posedge clk_in);
    line_out <= 1'b1;
    repeat (32) @(posedge clk_in);
  endtask
endmodule

/* File: sim/usart_async_receiver_bench.sv */
// Self-checking bench for the async serial receive path
`timescale 1ns/1ps
module usart_async_receiver_bench;
  logic       clk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       tx_active_in = 1'b0;
  logic       rx_line;
  logic [7:0] rdata_out;
  logic       rx_irq_out;
  logic       tx_inhibit_out;
  logic       sync_clock_out;
  logic       sync_clock_oe_n_out;
  logic       sync_data_oe_n_out;
  int         miscompares = 0;
  int         checked = 0;

  usr_receiver uut (
    .clk_in              (clk_in),
    .arst_n_in           (arst_n_in),
    .addr_in             (addr_in),
    .wdata_in            (wdata_in),
    .wr_in               (wr_in),
    .rd_in               (rd_in),
    .rx_pin_in           (rx_line),
    .tx_active_in        (tx_active_in),
    .rdata_out           (rdata_out),
    .rx_irq_out          (rx_irq_out),
    .tx_inhibit_out      (tx_inhibit_out),
    .sync_clock_out      (sync_clock_out),
    .sync_clock_oe_n_out (sync_clock_oe_n_out),
    .sync_data_oe_n_out  (sync_data_oe_n_out)
  );

  usr_far_tx far (
    .clk_in   (clk_in),
    .line_out (rx_line)
  );

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  task automatic ck(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask

  // One idle cycle after each access keeps strobes single-driven
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 ck(rdata_out, exp);
    @(posedge clk_in);
  endtask

  task automatic t_reset();
    #1 ck({3'h0, rx_irq_out, tx_inhibit_out, sync_clock_out,
           sync_clock_oe_n_out, sync_data_oe_n_out}, 8'h03);
    @(posedge clk_in);
    rc(8'h0C, 8'h00);
    rc(8'h18, 8'h00);
    rc(8'h19, 8'h00);
    rc(8'h1A, 8'h00);
    rc(8'h8C, 8'h00);
    rc(8'h98, 8'h02);
    rc(8'h99, 8'h00);
    rc(8'h55, 8'h00);
    wr(8'h8C, 8'hFF);
    rc(8'h8C, 8'h30);
    wr(8'h98, 8'hFF);
    rc(8'h98, 8'hF7);
    wr(8'h8C, 8'h00);
    $display("reset and access test done");
  endtask

  task automatic t_disabled();
    wr(8'h98, 8'h04);
    wr(8'h18, 8'h80);
    far.send(9'h0A5, 8, 1'b1);
    rc(8'h0C, 8'h00);
    $display("disabled test done");
  endtask

  task automatic t_basic();
    wr(8'h8C, 8'h20);
    wr(8'h18, 8'h90);
    far.send(9'h0A5, 8, 1'b1);
    rc(8'h0C, 8'h20);
    wr(8'h0C, 8'h00);
    rc(8'h0C, 8'h20);
    #1 ck({7'h0, rx_irq_out}, 8'h01);
    @(posedge clk_in);
    wr(8'h8C, 8'h00);
    #1 ck({7'h0, rx_irq_out}, 8'h00);
    @(posedge clk_in);
    rc(8'h1A, 8'hA5);
    rc(8'h0C, 8'h00);
    $display("basic test done");
  endtask

  task automatic t_overrun();
    far.send(9'h011, 8, 1'b1);
    far.send(9'h022, 8, 1'b1);
    far.send(9'h033, 8, 1'b1);
    rc(8'h18, 8'h92);
    rc(8'h1A, 8'h11);
    rc(8'h1A, 8'h22);
    far.send(9'h044, 8, 1'b1);
    rc(8'h0C, 8'h00);
    wr(8'h18, 8'h80);
    wr(8'h18, 8'h90);
    rc(8'h18, 8'h90);
    far.send(9'h055, 8, 1'b1);
    rc(8'h1A, 8'h55);
    $display("overrun test done");
  endtask

  task automatic t_framing();
    far.send(9'h066, 8, 1'b0);
    far.send(9'h077, 8, 1'b1);
    rc(8'h18, 8'h94);
    rc(8'h1A, 8'h66);
    rc(8'h18, 8'h90);
    rc(8'h1A, 8'h77);
    $display("framing test done");
  endtask

  task automatic t_ninth();
    wr(8'h18, 8'hD0);
    far.send(9'h15A, 9, 1'b1);
    far.send(9'h0A3, 9, 1'b1);
    rc(8'h18, 8'hD1);
    rc(8'h1A, 8'h5A);
    rc(8'h18, 8'hD0);
    rc(8'h1A, 8'hA3);
    $display("nine bit test done");
  endtask

  task automatic t_address();
    wr(8'h8C, 8'h20);
    wr(8'h18, 8'hD8);
    far.send(9'h012, 9, 1'b1);
    rc(8'h0C, 8'h00);
    #1 ck({7'h0, rx_irq_out}, 8'h00);
    far.send(9'h134, 9, 1'b1);
    rc(8'h18, 8'hD9);
    rc(8'h1A, 8'h34);
    wr(8'h18, 8'hD0);
    far.send(9'h056, 9, 1'b1);
    rc(8'h0C, 8'h20);
    rc(8'h1A, 8'h56);
    wr(8'h8C, 8'h00);
    $display("address test done");
  endtask

  // Abort inside the start bit; the rest of that frame is all ones
  task automatic t_abort();
    wr(8'h18, 8'h90);
    fork
      far.send(9'h0FF, 8, 1'b1);
    join_none
    repeat (12) @(posedge clk_in);
    wr(8'h18, 8'h80);
    repeat (8) @(posedge clk_in);
    wr(8'h18, 8'h90);
    repeat (200) @(posedge clk_in);
    rc(8'h0C, 8'h00);
    far.send(9'h03C, 8, 1'b1);
    rc(8'h1A, 8'h3C);
    $display("abort test done");
  endtask

  // Counts clock line changes over n edges; returns on an edge
  task automatic count_edges(input int n, output int toggles);
    logic last;
    toggles = 0;
    #1 last = sync_clock_out;
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (sync_clock_out !== last) begin
        toggles++;
      end
      last = sync_clock_out;
    end
    @(posedge clk_in);
  endtask

  // Transmit enable keeps the generator running for the clock line
  task automatic t_sync();
    int toggles;
    wr(8'h18, 8'h00);
    wr(8'h98, 8'hB4);
    #1 ck({7'h0, sync_clock_oe_n_out}, 8'h01);
    @(posedge clk_in);
    wr(8'h18, 8'h80);
    #1 ck({7'h0, sync_clock_oe_n_out}, 8'h00);
    ck({7'h0, sync_data_oe_n_out}, 8'h01);
    ck({7'h0, tx_inhibit_out}, 8'h00);
    count_edges(64, toggles);
    ck(8'(toggles), 8'h04);
    wr(8'h98, 8'hB0);
    repeat (80) @(posedge clk_in);
    count_edges(128, toggles);
    ck(8'(toggles), 8'h02);
    wr(8'h18, 8'h90);
    #1 ck({7'h0, tx_inhibit_out}, 8'h01);
    $display("sync master test done");
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_disabled();
    t_basic();
    t_overrun();
    t_framing();
    t_ninth();
    t_address();
    t_abort();
    t_sync();
    complete_run();
  end

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    miscompares++;
    complete_run();
  end
endmodule
